// ---- verilog/audio_serial_cfg.svh ----
`ifndef AUDIO_SERIAL_CFG_SVH
`define AUDIO_SERIAL_CFG_SVH

// Register byte offsets
`define ADDR_CONTROL 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CLEAR 8'h0C
`define ADDR_FORCE 8'h10
`define ADDR_MASK_SET 8'h14
`define ADDR_MASK_CLEAR 8'h18
`define ADDR_MASK_STATE 8'h1C
`define ADDR_RX_HOLD 8'h20
`define ADDR_TX_HOLD 8'h24

// Control word bits; the transmit bits sit one stride above the receive bits
`define CTL_RX_START 0
`define CTL_RX_STOP 1
`define CTL_CLK_START 2
`define CTL_CLK_STOP 3
`define CTL_DIR_STRIDE 4
`define CTL_SOFT_RESET 7

// Status flag positions
`define ST_RX_ENABLED 0
`define ST_RX_READY 1
`define ST_RX_OVERRUN 2
`define ST_TX_ENABLED 4
`define ST_TX_READY 5
`define ST_TX_UNDERRUN 6
`define ST_RX_CHANNELS 8
`define ST_TX_CHANNELS 20

// Reset values and writable masks
`define CONFIG_RESET 32'h0000_0000
`define CONFIG_WRITABLE 32'hFF00_771D
`define MASK_WRITABLE 32'h0000_0066
`define HOLD_RESET 32'h0000_0000

// Word length codes and sample widths in bits
`define WL_BITS_0 6'h20
`define WL_BITS_1 6'h18
`define WL_BITS_2 6'h14
`define WL_BITS_3 6'h12
`define WL_BITS_4 6'h10
`define WL_BITS_6 6'h08
`define WL_COMPACT16 3'h5
`define WL_COMPACT8 3'h7
`define WL_FULL 6'h20
`define HALF_SHIFT16 5'h10
`define HALF_SHIFT8 5'h08

// Bit clocks per slot, minus one
`define SLOT_LAST 5'h1F

`endif

// ---- verilog/audio_serial_pkg.sv ----
`default_nettype none
package audio_serial_pkg;

  typedef struct packed {
    logic slotWidth24;
    logic masterClockOutSel;
    logic [5:0] mckRatio;
    logic [8:0] rsvA;
    logic underrunRepeatSel;
    logic txDmaSplit;
    logic txMonoDuplicate;
    logic rsvB;
    logic rxLoopbackTest;
    logic rxDmaSplit;
    logic rxMonoDuplicate;
    logic [2:0] rsvC;
    logic [2:0] wordLengthSel;
    logic rsvD;
    logic masterMode;
  } serial_config_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef enum logic [1:0] {
    STOPPED = 2'h1,
    RUNNING = 2'h2
  } run_e;

endpackage

`default_nettype wire

// ---- verilog/audio_serial_mode_status.sv ----
// Functional notes
// - TX DMA split: one or two channels
// - RX DMA split: one or two channels
// - Mono duplicates left sample into right
// - Loopback routes serial out into serial in
// - Word length code sets sample width
// - Code 5 packs two 16-bit samples
// - Code 7 packs two 8-bit samples
// - Slave mode takes clocks from pins
// - Master mode derives and drives clocks
// - Master clock pin forwards source clock
// - TX underrun channel field, cleared together
// - RX overrun channel field, cleared together
// - TX underrun sticky until cleared
// - TX ready while running and holding word empty
// - TX enabled follows actual start/stop
// - RX overrun sticky until cleared
// - RX ready until holding word read
// - RX enabled follows actual start/stop
// - Clear register clears flags by ones
// - Force register sets error flags
// - Mask set and clear registers
// - Mask state register reads enables
// - Interrupt when flag and mask set
// - Underrun sends zero or previous sample
// - Received samples right-justified
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_cfg.svh"

module audio_serial_mode_status (
  input wire logic clk,
  input wire logic reset,
  input wire audio_serial_pkg::apb_req_s apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic genericSourceClock,
  input wire logic bitClockPinIn,
  output logic bitClockPinOut,
  output logic bitClockPinOe,
  input wire logic wordSelectPinIn,
  output logic wordSelectPinOut,
  output logic wordSelectPinOe,
  output logic serialDataOutPin,
  input wire logic serialDataInPin,
  output logic masterClockPin,
  output logic [1:0] txDmaReq,
  output logic [1:0] rxDmaReq
);
  import audio_serial_pkg::*;

  function automatic logic regAt(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  function automatic logic [5:0] wordBits(input logic [2:0] code);
    case (code)
      3'h0: return `WL_BITS_0;
      3'h1: return `WL_BITS_1;
      3'h2: return `WL_BITS_2;
      3'h3: return `WL_BITS_3;
      3'h4, 3'h5: return `WL_BITS_4;
      default: return `WL_BITS_6;
    endcase
  endfunction

  serial_config_s cfg;
  logic softReset;
  logic rst;
  logic [31:0] irq_mask_state;
  logic [31:0] readMux;
  logic [31:0] statusWord;
  logic setupPhase;
  logic accessDone;
  logic wrDone;
  logic [31:0] clrWord;
  logic [31:0] forceWord;
  logic thrWrite;
  logic rhrRead;
  logic [2:0] gSync;
  logic [2:0] bSync;
  logic [1:0] wSync;
  logic [1:0] dSync;
  logic ckRun;
  logic master;
  logic bckTog;
  logic fallTick;
  logic riseTick;
  logic wsLatched;
  logic [4:0] bitCnt;
  logic chan;
  logic nextChan;
  logic slotStart;
  logic frameStart;
  logic linkIdle;
  logic runReq [2];
  run_e runState [2];
  logic rxRunning;
  logic txRunning;
  logic [5:0] len;
  logic compact;
  logic [4:0] halfShift;
  logic reuseSlot;
  logic [31:0] fetchWord;
  logic [31:0] txSample;
  logic [31:0] txAligned;
  logic txLoad;
  logic txUnderrunEvt;
  logic txFull;
  logic [31:0] txHold;
  logic [31:0] txWord;
  logic [31:0] txShift;
  logic txUnderrun;
  logic [1:0] tx_underrun_channels;
  logic txReadyFlag;
  logic rxBit;
  logic [31:0] rxShift;
  logic [5:0] rxCnt;
  logic [31:0] rxMask;
  logic [31:0] rxSample;
  logic [31:0] rxLeft;
  logic [31:0] rxValue;
  logic rxStore;
  logic rxOverrunEvt;
  logic rxReady;
  logic rxOverrun;
  logic [1:0] rx_overrun_channels;
  logic [31:0] rxHold;
  logic rxHoldChan;

  // Soft reset takes one cycle to land and then clears itself
  assign rst = reset | softReset;

  // Bus slave: zero wait states, pready is the registered setup phase
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign accessDone = apbReq.psel & apbReq.penable & pready;
  assign wrDone = accessDone & apbReq.pwrite;
  assign clrWord = (wrDone & regAt(apbReq.paddr, `ADDR_CLEAR)) ? apbReq.pwdata : '0;
  assign forceWord = (wrDone & regAt(apbReq.paddr, `ADDR_FORCE)) ? apbReq.pwdata : '0;
  assign thrWrite = wrDone & regAt(apbReq.paddr, `ADDR_TX_HOLD);
  assign rhrRead = accessDone & ~apbReq.pwrite & regAt(apbReq.paddr, `ADDR_RX_HOLD);

  always_comb begin
    statusWord = '0;
    statusWord[`ST_RX_ENABLED] = rxRunning;
    statusWord[`ST_RX_READY] = rxReady;
    statusWord[`ST_RX_OVERRUN] = rxOverrun;
    statusWord[`ST_TX_ENABLED] = txRunning;
    statusWord[`ST_TX_READY] = txReadyFlag;
    statusWord[`ST_TX_UNDERRUN] = txUnderrun;
    statusWord[`ST_RX_CHANNELS +: 2] = rx_overrun_channels;
    statusWord[`ST_TX_CHANNELS +: 2] = tx_underrun_channels;
  end

  always_comb begin
    case (apbReq.paddr)
      `ADDR_CONFIG: readMux = cfg;
      `ADDR_STATUS: readMux = statusWord;
      `ADDR_MASK_STATE: readMux = irq_mask_state;
      `ADDR_RX_HOLD: readMux = rxHold;
      default: readMux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setupPhase;
      // Offsets above the holding words are unmapped and answer with an error
      pslverr <= setupPhase & (apbReq.paddr > `ADDR_TX_HOLD || apbReq.paddr[1:0] != 2'h0);
      prdata <= (setupPhase & ~apbReq.pwrite) ? readMux : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      softReset <= 1'b0;
    end else begin
      softReset <= wrDone & regAt(apbReq.paddr, `ADDR_CONTROL) & apbReq.pwdata[`CTL_SOFT_RESET];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= `CONFIG_RESET;
    end else if (wrDone & regAt(apbReq.paddr, `ADDR_CONFIG)) begin
      cfg <= apbReq.pwdata & `CONFIG_WRITABLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_state <= '0;
    end else if (wrDone & regAt(apbReq.paddr, `ADDR_MASK_SET)) begin
      irq_mask_state <= irq_mask_state | (apbReq.pwdata & `MASK_WRITABLE);
    end else if (wrDone & regAt(apbReq.paddr, `ADDR_MASK_CLEAR)) begin
      irq_mask_state <= irq_mask_state & ~apbReq.pwdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(statusWord & irq_mask_state);
    end
  end

  // Pin synchronisers; only the second stage and later are looked at
  always_ff @(posedge clk) begin
    if (reset) begin
      gSync <= '0;
      bSync <= '0;
      wSync <= '0;
      dSync <= '0;
    end else begin
      gSync <= {gSync[1:0], genericSourceClock};
      bSync <= {bSync[1:0], bitClockPinIn};
      wSync <= {wSync[0], wordSelectPinIn};
      dSync <= {dSync[0], serialDataInPin};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ckRun <= 1'b0;
    end else if (wrDone & regAt(apbReq.paddr, `ADDR_CONTROL)) begin
      if (apbReq.pwdata[`CTL_CLK_STOP]) begin
        ckRun <= 1'b0;
      end else if (apbReq.pwdata[`CTL_CLK_START]) begin
        ckRun <= 1'b1;
      end
    end
  end

  // Link timing; the source clock is only sampled, so it must stay well below clk/2
  assign master = cfg.masterMode;
  assign bckTog = master & ckRun & (cfg.masterClockOutSel ? (gSync[1] & ~gSync[2]) : (gSync[1] ^ gSync[2]));
  assign fallTick = master ? (bckTog & bitClockPinOut) : (~bSync[1] & bSync[2]);
  assign riseTick = master ? (bckTog & ~bitClockPinOut) : (bSync[1] & ~bSync[2]);
  assign slotStart = fallTick & (master ? (bitCnt == `SLOT_LAST) : (wsLatched != chan));
  assign nextChan = master ? ~chan : wsLatched;
  assign frameStart = slotStart & ~nextChan;
  assign linkIdle = master & ~ckRun;

  always_ff @(posedge clk) begin
    if (rst) begin
      bitClockPinOut <= 1'b0;
      bitClockPinOe <= 1'b0;
      wordSelectPinOe <= 1'b0;
      masterClockPin <= 1'b0;
      wsLatched <= 1'b0;
    end else begin
      if (~master | ~ckRun) begin
        bitClockPinOut <= 1'b0;
      end else if (bckTog) begin
        bitClockPinOut <= ~bitClockPinOut;
      end
      bitClockPinOe <= master;
      wordSelectPinOe <= master;
      masterClockPin <= master & ckRun & cfg.masterClockOutSel & gSync[1];
      if (riseTick) begin
        wsLatched <= wSync[1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bitCnt <= '0;
      wordSelectPinOut <= 1'b0;
    end else if (fallTick) begin
      bitCnt <= slotStart ? 5'h0 : bitCnt + 5'h1;
      if (slotStart) begin
        wordSelectPinOut <= nextChan;
      end
    end
  end
  assign chan = wordSelectPinOut;

  // Index 0 is the receiver, 1 the transmitter; both start on a frame edge and stop on one, or at once when the master clock is stopped
  for (genvar d = 0; d < 2; d++) begin : g_dir
    always_ff @(posedge clk) begin
      if (rst) begin
        runReq[d] <= 1'b0;
      end else if (wrDone & regAt(apbReq.paddr, `ADDR_CONTROL)) begin
        if (apbReq.pwdata[`CTL_RX_STOP + d * `CTL_DIR_STRIDE]) begin
          runReq[d] <= 1'b0;
        end else if (apbReq.pwdata[`CTL_RX_START + d * `CTL_DIR_STRIDE]) begin
          runReq[d] <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        runState[d] <= STOPPED;
      end else begin
        case (runState[d])
          STOPPED: if (runReq[d] & frameStart) runState[d] <= RUNNING;
          RUNNING: if (~runReq[d] & (frameStart | linkIdle)) runState[d] <= STOPPED;
          default: runState[d] <= STOPPED;
        endcase
      end
    end
  end
  assign rxRunning = runState[0] == RUNNING;
  assign txRunning = runState[1] == RUNNING;

  // Sample formatting shared by both directions
  assign len = wordBits(cfg.wordLengthSel);
  assign compact = cfg.wordLengthSel == `WL_COMPACT16 || cfg.wordLengthSel == `WL_COMPACT8;
  assign halfShift = cfg.wordLengthSel == `WL_COMPACT16 ? `HALF_SHIFT16 : `HALF_SHIFT8;

  // Transmit path
  assign reuseSlot = nextChan & (compact | cfg.txMonoDuplicate);
  assign fetchWord = txFull ? txHold : (cfg.underrunRepeatSel ? txWord : '0);
  assign txSample = reuseSlot ? (compact ? txWord >> halfShift : txWord) : fetchWord;
  assign txAligned = txSample << (`WL_FULL - len);
  assign txLoad = slotStart & txRunning & ~reuseSlot;
  assign txUnderrunEvt = txLoad & ~txFull;
  assign txReadyFlag = ~txFull & txRunning;

  always_ff @(posedge clk) begin
    if (rst) begin
      txFull <= 1'b0;
      txHold <= `HOLD_RESET;
    end else begin
      txFull <= (txFull & ~txLoad) | thrWrite;
      if (thrWrite) begin
        txHold <= apbReq.pwdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txShift <= '0;
      txWord <= '0;
      serialDataOutPin <= 1'b0;
    end else if (fallTick) begin
      if (slotStart & txRunning) begin
        txShift <= txAligned << 1;
        serialDataOutPin <= txAligned[31];
        if (~reuseSlot) begin
          txWord <= fetchWord;
        end
      end else if (slotStart) begin
        txShift <= '0;
        serialDataOutPin <= 1'b0;
      end else begin
        txShift <= txShift << 1;
        serialDataOutPin <= txShift[31];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txUnderrun <= 1'b0;
      tx_underrun_channels <= '0;
    end else begin
      // Hardware and forced sets win over a clear in the same cycle
      txUnderrun <= (txUnderrun & ~clrWord[`ST_TX_UNDERRUN]) | forceWord[`ST_TX_UNDERRUN] | txUnderrunEvt;
      tx_underrun_channels <= (tx_underrun_channels & ~clrWord[`ST_TX_CHANNELS +: 2] & ~{2{clrWord[`ST_TX_UNDERRUN]}})
        | forceWord[`ST_TX_CHANNELS +: 2] | (txUnderrunEvt ? 2'h1 << nextChan : 2'h0);
    end
  end

  // Receive path
  assign rxBit = cfg.rxLoopbackTest ? serialDataOutPin : dSync[1];
  assign rxMask = (len == `WL_FULL) ? '1 : (32'h0000_0001 << len) - 32'h0000_0001;
  assign rxSample = rxShift & rxMask;
  assign rxValue = compact
    ? (cfg.wordLengthSel == `WL_COMPACT16 ? {rxSample[15:0], rxLeft[15:0]}
      : {16'h0000, rxSample[7:0], rxLeft[7:0]})
    : ((cfg.rxMonoDuplicate & chan) ? rxLeft : rxSample);
  assign rxStore = slotStart & rxRunning & (rxCnt == len) & ~(compact & ~chan);
  assign rxOverrunEvt = rxStore & rxReady;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxShift <= '0;
      rxCnt <= '0;
      rxLeft <= '0;
    end else if (slotStart) begin
      rxCnt <= '0;
      if (~chan) begin
        rxLeft <= rxSample;
      end
    end else if (riseTick & (rxCnt < len)) begin
      rxShift <= {rxShift[30:0], rxBit};
      rxCnt <= rxCnt + 6'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxHold <= `HOLD_RESET;
      rxHoldChan <= 1'b0;
      rxReady <= 1'b0;
    end else begin
      if (rxStore) begin
        rxHold <= rxValue;
        rxHoldChan <= chan;
      end
      rxReady <= (rxReady & ~rhrRead) | rxStore;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxOverrun <= 1'b0;
      rx_overrun_channels <= '0;
    end else begin
      rxOverrun <= (rxOverrun & ~clrWord[`ST_RX_OVERRUN]) | forceWord[`ST_RX_OVERRUN] | rxOverrunEvt;
      rx_overrun_channels <= (rx_overrun_channels & ~clrWord[`ST_RX_CHANNELS +: 2] & ~{2{clrWord[`ST_RX_OVERRUN]}})
        | forceWord[`ST_RX_CHANNELS +: 2] | (rxOverrunEvt ? 2'h1 << chan : 2'h0);
    end
  end

  // DMA requests; split mode names the audio channel the word belongs to
  always_ff @(posedge clk) begin
    if (rst) begin
      txDmaReq <= '0;
      rxDmaReq <= '0;
    end else begin
      txDmaReq <= txReadyFlag ? (cfg.txDmaSplit ? 2'h1 << ~chan : 2'h1) : 2'h0;
      rxDmaReq <= rxReady ? (cfg.rxDmaSplit ? 2'h1 << rxHoldChan : 2'h1) : 2'h0;
    end
  end

endmodule // audio_serial_mode_status

`default_nettype wire

// ---- bench/audio_serial_mode_status_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module audio_serial_mode_status_sva (
  input wire logic clk,
  input wire logic reset,
  input wire audio_serial_pkg::apb_req_s apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic irq,
  input wire logic bitClockPinOe,
  input wire logic wordSelectPinOe,
  input wire logic masterClockPin,
  input wire logic [1:0] txDmaReq,
  input wire logic [1:0] rxDmaReq
);
  import audio_serial_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic wrDone;
  logic softReset;
  serial_config_s cfg;
  logic [6:0] mask;
  logic [3:0] quiet;
  assign wrDone = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;
  assign softReset = wrDone && apbReq.paddr == 8'h00 && apbReq.pwdata[7];
  always_ff @(posedge clk) begin
    if (reset || softReset) begin
      cfg <= '0;
    end else if (wrDone && apbReq.paddr == 8'h04) begin
      cfg <= serial_config_s'(apbReq.pwdata & 32'hFF00_771D);
    end
  end
  always_ff @(posedge clk) begin
    if (reset || softReset) begin
      mask <= '0;
    end else if (wrDone && apbReq.paddr == 8'h14) begin
      mask <= mask | (apbReq.pwdata[6:0] & 7'h66);
    end else if (wrDone && apbReq.paddr == 8'h18) begin
      mask <= mask & ~apbReq.pwdata[6:0];
    end
  end
  // Outputs are registered, so judge them only once writes have settled
  always_ff @(posedge clk) begin
    if (reset || wrDone) begin
      quiet <= 4'h0;
    end else if (quiet != 4'h3) begin
      quiet <= quiet + 4'h1;
    end
  end
  sequence s_forceWrite;
    wrDone && apbReq.paddr == 8'h10 && apbReq.pwdata[6] && mask[6];
  endsequence
  property p_slave_in;
    quiet == 4'h3 && !cfg.masterMode |-> !bitClockPinOe && !wordSelectPinOe;
  endproperty
  a_slave_in: assert property (p_slave_in) else $error("link pins driven in slave mode");
  property p_master_out;
    quiet == 4'h3 && cfg.masterMode |-> bitClockPinOe && wordSelectPinOe;
  endproperty
  a_master_out: assert property (p_master_out) else $error("link pins idle in master mode");
  property p_mck_idle;
    quiet == 4'h3 && !(cfg.masterMode && cfg.masterClockOutSel) |-> !masterClockPin;
  endproperty
  a_mck_idle: assert property (p_mck_idle) else $error("master clock pin active");
  property p_tx_single;
    quiet == 4'h3 && !cfg.txDmaSplit |-> !txDmaReq[1];
  endproperty
  a_tx_single: assert property (p_tx_single) else $error("second tx channel used");
  property p_rx_single;
    quiet == 4'h3 && !cfg.rxDmaSplit |-> !rxDmaReq[1];
  endproperty
  a_rx_single: assert property (p_rx_single) else $error("second rx channel used");
  property p_irq_masked;
    quiet == 4'h3 && mask == 7'h00 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with all sources masked");
  property p_mask_read;
    apbReq.psel && apbReq.penable && pready && !apbReq.pwrite && apbReq.paddr == 8'h1C |-> prdata == 32'(mask);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask state read wrong");
  property p_force_irq;
    s_forceWrite |-> ##[1:3] irq;
  endproperty
  a_force_irq: assert property (p_force_irq) else $error("forced underrun gave no irq");
endmodule // audio_serial_mode_status_sva
bind audio_serial_mode_status audio_serial_mode_status_sva chk_u (
  .clk(clk), .reset(reset), .apbReq(apbReq), .prdata(prdata), .pready(pready), .irq(irq),
  .bitClockPinOe(bitClockPinOe), .wordSelectPinOe(wordSelectPinOe), .masterClockPin(masterClockPin),
  .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq)
);
`default_nettype wire

// ---- bench/codec_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  input wire logic run,
  output logic bitClk,
  output logic wordSel,
  output logic dataOut
);
  int bitCount = 0;
  initial begin
    bitClk = 1'b0;
    wordSel = 1'b0;
    dataOut = 1'b0;
    #37;
    forever begin
      #100;
      // Clock runs only while run is high and parks low
      if (run || bitClk) begin
        bitClk = ~bitClk;
        if (!bitClk) begin
          bitCount++;
          // Word select moves on a falling edge every slot
          if (bitCount % 32 == 0) wordSel = ~wordSel;
        end
      end
      // Keeps changing so a loopback that leaks this pin shows up
      dataOut = ~dataOut ^ bitCount[1];
    end
  end
endmodule // codec_model
`default_nettype wire

// ---- bench/audio_serial_mode_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module audio_serial_mode_status_tb;
  import audio_serial_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic linkRun = 1'b0;
  logic [2:0] srcDiv = 3'h0;
  apb_req_s apbReq = '0;
  logic [31:0] prdata, rdVal;
  logic pready, pslverr, errVal, irq, bitOut, bitOe, wsOut, wsOe, sdo, mckPin, pBc, pWs, pSd;
  logic [1:0] tx_dma_split, rx_dma_split;
  int mismatches = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) srcDiv <= srcDiv + 3'h1;
  audio_serial_mode_status dut_u (
    .clk(clk), .reset(reset), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .genericSourceClock(srcDiv[2]), .bitClockPinIn(bitOe ? bitOut : pBc), .bitClockPinOut(bitOut),
    .bitClockPinOe(bitOe), .wordSelectPinIn(wsOe ? wsOut : pWs), .wordSelectPinOut(wsOut),
    .wordSelectPinOe(wsOe), .serialDataOutPin(sdo), .serialDataInPin(pSd), .masterClockPin(mckPin),
    .txDmaReq(tx_dma_split), .rxDmaReq(rx_dma_split)
  );
  codec_model codec_u (.run(linkRun), .bitClk(pBc), .wordSel(pWs), .dataOut(pSd));
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic note(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n = 0;
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, wr, addr, data};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdVal = prdata;
    errVal = pslverr;
    apbReq <= '0;
    if (pready !== 1'b1) begin
      note(32'h0, 32'h1);
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    note(rdVal, exp);
  endtask
  // Start and stop wait for a frame boundary, so poll under a bound
  task automatic waitStatus(input logic [31:0] sel, input logic [31:0] want);
    int n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while ((rdVal & sel) !== want && n < 400);
    note(rdVal & sel, want);
    if ((rdVal & sel) !== want) wrap_up();
  endtask
  task automatic t_regs();
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    for (int a = 12; a <= 24; a += 4) rd(8'(a), 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0);
    note(32'(errVal), 32'h1);
  endtask
  task automatic t_mask();
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0066);
    apb(1'b1, 8'h18, 32'h0000_0022);
    apb(1'b1, 8'h14, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0044);
  endtask
  task automatic t_force();
    apb(1'b1, 8'h10, 32'h0030_0344);
    rd(8'h08, 32'h0030_0344);
    repeat (2) @(posedge clk);
    note(32'(irq), 32'h1);
    apb(1'b1, 8'h18, 32'h0000_0044);
    repeat (2) @(posedge clk);
    note(32'(irq), 32'h0);
    apb(1'b1, 8'h14, 32'h0000_0044);
    apb(1'b1, 8'h0C, 32'h0000_0004);
    rd(8'h08, 32'h0030_0040);
    apb(1'b1, 8'h0C, 32'h0000_0040);
    rd(8'h08, 32'h0000_0000);
    note(32'(irq), 32'h0);
  endtask
  task automatic t_master();
    int hi = 0;
    int mc = 0;
    apb(1'b1, 8'h04, 32'h4000_0001);
    apb(1'b1, 8'h00, 32'h0000_0004);
    repeat (200) begin
      @(posedge clk);
      hi += bitOut;
      mc += mckPin;
    end
    note(32'(bitOe & wsOe), 32'h1);
    note(32'(hi > 0 && hi < 200), 32'h1);
    note(32'(mc > 0 && mc < 200), 32'h1);
    apb(1'b1, 8'h00, 32'h0000_0008);
    apb(1'b1, 8'h04, 32'h0000_0000);
    repeat (3) @(posedge clk);
    note(32'(bitOe | wsOe), 32'h0);
  endtask
  // Loopback; one word written, so later slots underrun
  task automatic t_link(input logic [31:0] cfgWord, input logic [31:0] txVal, input logic [31:0] want,
    input logic [3:0] dmaWant);
    apb(1'b1, 8'h04, cfgWord);
    linkRun <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000_0011);
    waitStatus(32'h0000_0031, 32'h0000_0031);
    apb(1'b1, 8'h24, txVal);
    apb(1'b0, 8'h08, 32'h0);
    note(rdVal & 32'h0000_0020, 32'h0);
    repeat (1100) @(posedge clk);
    apb(1'b0, 8'h08, 32'h0);
    note(rdVal & 32'h0000_0046, 32'h0000_0046);
    // Checked early in a left slot, so a split transmitter asks for the right channel
    note(32'({tx_dma_split, rx_dma_split}), 32'(dmaWant));
    rd(8'h20, want);
    apb(1'b0, 8'h08, 32'h0);
    note(rdVal & 32'h0000_0002, 32'h0);
    apb(1'b1, 8'h00, 32'h0000_0022);
    waitStatus(32'h0000_0011, 32'h0);
    linkRun <= 1'b0;
    apb(1'b1, 8'h0C, 32'h0030_0344);
  endtask
  // Soft reset while both directions run must stop them and restore the config, status and mask state registers
  task automatic t_soft();
    apb(1'b1, 8'h04, 32'h0000_0001);
    apb(1'b1, 8'h14, 32'h0000_0066);
    apb(1'b1, 8'h00, 32'h0000_0015);
    waitStatus(32'h0000_0011, 32'h0000_0011);
    note(32'(irq), 32'h1);
    apb(1'b1, 8'h00, 32'h0000_0080);
    rd(8'h08, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    note(32'({bitOe, wsOe, irq}), 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_mask();
    t_force();
    t_master();
    t_link(32'h0000_4410, 32'h0000_A5C3, 32'h0000_A5C3, 4'h5);
    t_link(32'h0000_0410, 32'h0000_A5C3, 32'h0000_0000, 4'h5);
    t_link(32'h0000_2614, 32'h1234_A5C3, 32'h1234_A5C3, 4'hA);
    t_link(32'h0000_041C, 32'hFFFF_C35A, 32'h0000_C35A, 4'h5);
    t_soft();
    wrap_up();
  end
endmodule // audio_serial_mode_status_tb
`default_nettype wire
